// File: pis_irq_ctrl.sv
// PHY interrupt flags, enable register and special control/status register behind APB
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none

// How it works
// (R1) Page received sets sticky flag bit 1
// (R2) Enable register, 16 bits, index 30
// (R3) Enable one allows, zero blocks; reset zero
// (R4) Enable bit 9 gates link up
// (R5) Enable bit 7 gates energy detected
// (R6) Enable bit 6 gates negotiation complete
// (R7) Enable bit 5 gates remote fault
// (R8) Enable bit 4 gates link down
// (R9) Enable bit 3 gates partner acknowledge
// (R10) Enable bit 2 gates parallel detect fault
// (R11) Enable bit 1 gates page; reserved read-only
// (R12) Special register, 16 bits, index 31
// (R13) Bit 12 shows negotiation done
// (R14) Field 11:5 resets 0000010b, software rewrites it
// (R15) Field 4:2 reports speed and duplex
// (R16) Enabled flags latch and stay set
// (R17) Reading flags register clears all flags
// (R18) Interrupt high while enabled flag set
module pis_irq_ctrl (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pis_pkg::ADDR_W-1:0] paddr,
	input wire logic [pis_pkg::DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [pis_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Physical layer status, asynchronous to sys_clk
	input wire pis_pkg::pis_phy_ev_s phyEvents,
	// Interrupt request
	output logic phyIrq
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Word-aligned register hit; the low two address bits are ignored
	function automatic logic regHit(input logic [pis_pkg::ADDR_W-1:0] addr, input logic [5:0] idx);
		regHit = (addr[pis_pkg::ADDR_W-1:2] == idx);
	endfunction

	pis_pkg::pis_state_s st_reg;
	pis_pkg::pis_state_s st_next;
	logic [15:0] evVec;
	logic accessDone;
	logic flagsRead;
	logic [15:0] specialView;

	// ----------------------------------------------------------------
	// Event detection on synchronised levels
	// ----------------------------------------------------------------
	// Edges are taken from the second stage only, so a metastable first stage never reaches logic
	always_comb begin
		evVec = 16'h0000;
		// (R1) page received event
		evVec[pis_pkg::BIT_PAGE_RX] = st_reg.sync2.pageRx & ~st_reg.prev.pageRx;
		// (R10) parallel detect fault event
		evVec[pis_pkg::BIT_PAR_FAULT] = st_reg.sync2.parDetectFault & ~st_reg.prev.parDetectFault;
		// (R9) partner acknowledge event
		evVec[pis_pkg::BIT_LP_ACK] = st_reg.sync2.lpAck & ~st_reg.prev.lpAck;
		// (R8) link down: falling edge of link status
		evVec[pis_pkg::BIT_LINK_DOWN] = ~st_reg.sync2.linkStatus & st_reg.prev.linkStatus;
		// (R7) remote fault event
		evVec[pis_pkg::BIT_REMOTE_FAULT] = st_reg.sync2.remoteFault & ~st_reg.prev.remoteFault;
		// (R6) negotiation complete event
		evVec[pis_pkg::BIT_ANEG_DONE] = st_reg.sync2.anegComplete & ~st_reg.prev.anegComplete;
		// (R5) energy detected event
		evVec[pis_pkg::BIT_ENERGY] = st_reg.sync2.energyDetected & ~st_reg.prev.energyDetected;
		// (R4) link up: rising edge of link status
		evVec[pis_pkg::BIT_LINK_UP] = st_reg.sync2.linkStatus & ~st_reg.prev.linkStatus;
	end

	// ----------------------------------------------------------------
	// Bus strobes and read view
	// ----------------------------------------------------------------
	// The access completes at the edge where pready is already high
	assign accessDone = psel & penable & st_reg.pready;
	// (R17) a completed read of the flags register
	assign flagsRead = accessDone & ~pwrite & regHit(paddr, pis_pkg::IDX_IRQ_FLAGS);

	// Special register as software sees it
	always_comb begin
		specialView = 16'h0000;
		// (R13) done bit follows the synchronised negotiation status
		specialView[pis_pkg::SPC_AUTODONE] = st_reg.sync2.anegComplete;
		// (R14) reserved field reads back what was stored
		specialView[pis_pkg::SPC_RESV_LO +: pis_pkg::SPC_RESV_W] = st_reg.resvReg;
		// (R15) speed and duplex code passes straight through
		specialView[pis_pkg::SPC_SPEED_LO +: 3] = st_reg.sync2.speedDuplex;
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		// Two-stage synchronisers and edge history
		st_next.sync1 = phyEvents;
		st_next.sync2 = st_reg.sync1;
		st_next.prev = st_reg.sync2;

		// One wait state: pready rises after the first access cycle and drops after completion
		st_next.pready = psel & penable & ~st_reg.pready;
		st_next.pslverr = 1'b0;
		st_next.prdata = st_reg.prdata;

		if (psel && penable && !st_reg.pready) begin
			st_next.prdata = 32'h0000_0000;
			if (regHit(paddr, pis_pkg::IDX_IRQ_FLAGS)) begin
				st_next.prdata[15:0] = st_reg.flagsReg;
			end else if (regHit(paddr, pis_pkg::IDX_IRQ_ENABLE)) begin
				// (R2) enable register readable
				st_next.prdata[15:0] = st_reg.enableReg;
			end else if (regHit(paddr, pis_pkg::IDX_SPECIAL)) begin
				// (R12) special register readable
				st_next.prdata[15:0] = specialView;
			end else begin
				// Unmapped words answer with an error and zero data
				st_next.pslverr = 1'b1;
			end
		end

		// Register writes take effect at the completing edge
		if (accessDone && pwrite) begin
			if (regHit(paddr, pis_pkg::IDX_IRQ_ENABLE)) begin
				// (R11) reserved enable bits stay zero through the write mask
				if (pstrb[0]) begin
					st_next.enableReg[7:0] = pwdata[7:0] & pis_pkg::ENABLE_WMASK[7:0];
				end
				if (pstrb[1]) begin
					st_next.enableReg[15:8] = pwdata[15:8] & pis_pkg::ENABLE_WMASK[15:8];
				end
			end else if (regHit(paddr, pis_pkg::IDX_SPECIAL)) begin
				// (R14) stored as written; software is expected to write the reset pattern
				if (pstrb[0]) begin
					st_next.resvReg[2:0] = pwdata[7:5];
				end
				if (pstrb[1]) begin
					st_next.resvReg[6:3] = pwdata[11:8];
				end
			end
		end

		// Flag clearing: a flags read clears all, a write of ones clears those bits
		if (flagsRead) begin
			st_next.flagsReg = 16'h0000;
		end else if (accessDone && pwrite && regHit(paddr, pis_pkg::IDX_IRQ_FLAGS)) begin
			st_next.flagsReg = st_reg.flagsReg & ~{pstrb[1] ? pwdata[15:8] : 8'h00, pstrb[0] ? pwdata[7:0] : 8'h00};
		end

		// (R16) enabled events latch and win over a clear in the same cycle
		// (R3) a zero enable bit blocks its source; bits 4..9 follow the same gating
		st_next.flagsReg = st_next.flagsReg | (evVec & st_reg.enableReg & pis_pkg::ENABLE_WMASK);

		// (R18) level request from enabled set flags, registered from next values
		st_next.irq = |(st_next.flagsReg & st_next.enableReg);
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Synchronous reset; every field takes a constant
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_reg.sync1 <= '0;
			st_reg.sync2 <= '0;
			st_reg.prev <= '0;
			// (R3) all sources start blocked
			st_reg.enableReg <= pis_pkg::ENABLE_RESET;
			// (R1) flags reset to zero
			st_reg.flagsReg <= pis_pkg::FLAGS_RESET;
			// (R14) reserved field reset pattern
			st_reg.resvReg <= pis_pkg::SPC_RESV_RESET;
			st_reg.prdata <= 32'h0000_0000;
			st_reg.pready <= 1'b0;
			st_reg.pslverr <= 1'b0;
			st_reg.irq <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from flip-flops
	assign prdata = st_reg.prdata;
	assign pready = st_reg.pready;
	assign pslverr = st_reg.pslverr;
	assign phyIrq = st_reg.irq;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cbClk @(posedge sys_clk);
	endclocking
	default disable iff (srst);

	sequence seqAccessWait;
		psel && penable && !pready;
	endsequence

	sequence seqAccessDone;
		psel && penable && pready;
	endsequence

	// (R3) reset blocks every source
	a_enable_reset_zero: assert property (disable iff (1'b0) srst |=> st_reg.enableReg == 16'h0000) else $error("enable not zero after reset");

	// (R11) reserved enable bits never set
	a_enable_reserved_zero: assert property ((st_reg.enableReg & ~pis_pkg::ENABLE_WMASK) == 16'h0000) else $error("reserved enable bit set");

	// (R1) enabled page event latches bit 1
	a_page_flag_latch: assert property (evVec[1] && st_reg.enableReg[1] |=> st_reg.flagsReg[1]) else $error("page flag not latched");

	// (R16) flag held until a flags read or clearing write
	a_flag_sticky_hold: assert property (st_reg.flagsReg[6] && !(accessDone && regHit(paddr, pis_pkg::IDX_IRQ_FLAGS)) |=> st_reg.flagsReg[6]) else $error("flag dropped without clear");

	// (R9) blocked source never raises its flag
	a_blocked_source_quiet: assert property (!st_reg.enableReg[3] && !st_reg.flagsReg[3] |=> !st_reg.flagsReg[3]) else $error("masked flag set");

	// (R17) read clears all flags when no event coincides
	a_read_clears_flags: assert property (flagsRead && evVec == 16'h0000 |=> st_reg.flagsReg == 16'h0000) else $error("flags not cleared by read");

	// (R18) interrupt equals enabled flag set
	a_irq_tracks_flags: assert property (phyIrq == |(st_reg.flagsReg & st_reg.enableReg)) else $error("irq mismatch");

	// (R14) reserved pattern after reset
	a_resv_reset_pattern: assert property (disable iff (1'b0) srst |=> st_reg.resvReg == 7'b0000010) else $error("reserved field reset wrong");

	// (R13) done bit is the negotiation level two edges after the pin
	a_autodone_follows: assert property (##2 specialView[12] == $past(phyEvents.anegComplete, 2)) else $error("autodone lags wrongly");

	// (R2) bus answers after exactly one wait cycle, then releases
	a_apb_one_wait: assert property (seqAccessWait |=> pready ##1 !pready) else $error("pready timing wrong");

	// (R12) completion pulse is a single cycle
	a_apb_done_pulse: assert property (seqAccessDone |=> !pready) else $error("pready held too long");

	// ----------------------------------------------------------------
	// Per-source latching and blocking
	// ----------------------------------------------------------------
	// Each enabled source must latch its own flag at the next edge

	// (R10) parallel fault latches when enabled
	a_parfault_flag_latch: assert property ( // (R10)
		evVec[pis_pkg::BIT_PAR_FAULT] && st_reg.enableReg[pis_pkg::BIT_PAR_FAULT] |=>
		st_reg.flagsReg[pis_pkg::BIT_PAR_FAULT]) else $error("parallel fault flag not latched");

	// (R9) partner acknowledge latches when enabled
	a_lpack_flag_latch: assert property ( // (R9)
		evVec[pis_pkg::BIT_LP_ACK] && st_reg.enableReg[pis_pkg::BIT_LP_ACK] |=>
		st_reg.flagsReg[pis_pkg::BIT_LP_ACK]) else $error("partner ack flag not latched");

	// (R8) link down latches when enabled
	a_linkdown_flag_latch: assert property ( // (R8)
		evVec[pis_pkg::BIT_LINK_DOWN] && st_reg.enableReg[pis_pkg::BIT_LINK_DOWN] |=>
		st_reg.flagsReg[pis_pkg::BIT_LINK_DOWN]) else $error("link down flag not latched");

	// (R7) remote fault latches when enabled
	a_rfault_flag_latch: assert property ( // (R7)
		evVec[pis_pkg::BIT_REMOTE_FAULT] && st_reg.enableReg[pis_pkg::BIT_REMOTE_FAULT] |=>
		st_reg.flagsReg[pis_pkg::BIT_REMOTE_FAULT]) else $error("remote fault flag not latched");

	// (R6) negotiation done latches when enabled
	a_aneg_flag_latch: assert property ( // (R6)
		evVec[pis_pkg::BIT_ANEG_DONE] && st_reg.enableReg[pis_pkg::BIT_ANEG_DONE] |=>
		st_reg.flagsReg[pis_pkg::BIT_ANEG_DONE]) else $error("negotiation flag not latched");

	// (R5) energy detect latches when enabled
	a_energy_flag_latch: assert property ( // (R5)
		evVec[pis_pkg::BIT_ENERGY] && st_reg.enableReg[pis_pkg::BIT_ENERGY] |=>
		st_reg.flagsReg[pis_pkg::BIT_ENERGY]) else $error("energy flag not latched");

	// (R4) link up latches when enabled
	a_linkup_flag_latch: assert property ( // (R4)
		evVec[pis_pkg::BIT_LINK_UP] && st_reg.enableReg[pis_pkg::BIT_LINK_UP] |=>
		st_reg.flagsReg[pis_pkg::BIT_LINK_UP]) else $error("link up flag not latched");

	// (R11) blocked page source stays quiet
	a_page_blocked_quiet: assert property ( // (R11)
		!st_reg.enableReg[pis_pkg::BIT_PAGE_RX] && !st_reg.flagsReg[pis_pkg::BIT_PAGE_RX] |=>
		!st_reg.flagsReg[pis_pkg::BIT_PAGE_RX]) else $error("masked page flag set");

	// (R10) blocked parallel fault stays quiet
	a_parfault_blocked_quiet: assert property ( // (R10)
		!st_reg.enableReg[pis_pkg::BIT_PAR_FAULT] && !st_reg.flagsReg[pis_pkg::BIT_PAR_FAULT] |=>
		!st_reg.flagsReg[pis_pkg::BIT_PAR_FAULT]) else $error("masked parallel fault flag set");

	// (R8) blocked link down stays quiet
	a_linkdown_blocked_quiet: assert property ( // (R8)
		!st_reg.enableReg[pis_pkg::BIT_LINK_DOWN] && !st_reg.flagsReg[pis_pkg::BIT_LINK_DOWN] |=>
		!st_reg.flagsReg[pis_pkg::BIT_LINK_DOWN]) else $error("masked link down flag set");

	// (R7) blocked remote fault stays quiet
	a_rfault_blocked_quiet: assert property ( // (R7)
		!st_reg.enableReg[pis_pkg::BIT_REMOTE_FAULT] && !st_reg.flagsReg[pis_pkg::BIT_REMOTE_FAULT] |=>
		!st_reg.flagsReg[pis_pkg::BIT_REMOTE_FAULT]) else $error("masked remote fault flag set");

	// (R6) blocked negotiation source stays quiet
	a_aneg_blocked_quiet: assert property ( // (R6)
		!st_reg.enableReg[pis_pkg::BIT_ANEG_DONE] && !st_reg.flagsReg[pis_pkg::BIT_ANEG_DONE] |=>
		!st_reg.flagsReg[pis_pkg::BIT_ANEG_DONE]) else $error("masked negotiation flag set");

	// (R5) blocked energy source stays quiet
	a_energy_blocked_quiet: assert property ( // (R5)
		!st_reg.enableReg[pis_pkg::BIT_ENERGY] && !st_reg.flagsReg[pis_pkg::BIT_ENERGY] |=>
		!st_reg.flagsReg[pis_pkg::BIT_ENERGY]) else $error("masked energy flag set");

	// (R4) blocked link up stays quiet
	a_linkup_blocked_quiet: assert property ( // (R4)
		!st_reg.enableReg[pis_pkg::BIT_LINK_UP] && !st_reg.flagsReg[pis_pkg::BIT_LINK_UP] |=>
		!st_reg.flagsReg[pis_pkg::BIT_LINK_UP]) else $error("masked link up flag set");

	// ----------------------------------------------------------------
	// Register views and bus answers
	// ----------------------------------------------------------------
	// (R12) unused special bits read zero
	a_special_unused_zero: assert property ( // (R12)
		specialView[15:13] == 3'b000 && specialView[1:0] == 2'b00) else $error("special unused bits set");

	// (R15) speed code follows the pins two edges later
	a_speed_follows: assert property ( // (R15)
		##2 specialView[4:2] == $past(phyEvents.speedDuplex, 2)) else $error("speed code lags wrongly");

	// (R16) reserved flag positions never latch
	a_flags_reserved_zero: assert property ( // (R16)
		(st_reg.flagsReg & ~pis_pkg::ENABLE_WMASK) == 16'h0000) else $error("reserved flag bit set");

	// (R2) a full-width enable write lands masked
	a_enable_write_lands: assert property ( // (R2)
		accessDone && pwrite && regHit(paddr, pis_pkg::IDX_IRQ_ENABLE) && pstrb[1:0] == 2'b11 |=>
		{16'h0000, st_reg.enableReg} == ($past(pwdata) & {16'h0000, pis_pkg::ENABLE_WMASK}))
		else $error("enable write lost");

	// (R16) write of one clears the page flag when no event coincides
	a_w1c_clears_flag: assert property ( // (R16)
		accessDone && pwrite && regHit(paddr, pis_pkg::IDX_IRQ_FLAGS) && pstrb[0] && pwdata[1] && !evVec[1] |=>
		!st_reg.flagsReg[1]) else $error("write one did not clear");

	// (R1) flags read returns the latched value captured at the answer
	a_read_returns_flags: assert property ( // (R1)
		seqAccessWait && !pwrite && regHit(paddr, pis_pkg::IDX_IRQ_FLAGS) |=>
		prdata[15:0] == $past(st_reg.flagsReg)) else $error("flags read data wrong");

	// (R12) upper read lanes carry no data
	a_prdata_upper_zero: assert property ( // (R12)
		prdata[31:16] == 16'h0000) else $error("upper read data set");

	// (R12) unmapped words answer with an error
	a_unmapped_error: assert property ( // (R12)
		seqAccessWait && !regHit(paddr, pis_pkg::IDX_IRQ_FLAGS) && !regHit(paddr, pis_pkg::IDX_IRQ_ENABLE) &&
		!regHit(paddr, pis_pkg::IDX_SPECIAL) |=> pslverr) else $error("unmapped access without error");

	// (R12) error only appears together with the answer
	a_error_with_ready: assert property ( // (R12)
		pslverr |-> pready) else $error("error without ready");

	// (R18) request is low right after reset
	a_irq_low_reset: assert property ( // (R18)
		disable iff (1'b0) srst |=> !phyIrq) else $error("irq high after reset");

	// (R8) link up and link down never coincide
	a_link_edges_apart: assert property ( // (R8)
		!(evVec[pis_pkg::BIT_LINK_UP] && evVec[pis_pkg::BIT_LINK_DOWN])) else $error("both link edges at once");

endmodule

`default_nettype wire

// File: pis_pkg.sv
// Constants and carrier types for the PHY interrupt enable and special status block
`default_nettype none

package pis_pkg;

	// ----------------------------------------------------------------
	// Register indices and bus widths
	// ----------------------------------------------------------------
	localparam logic [5:0] IDX_IRQ_FLAGS = 6'd29;
	localparam logic [5:0] IDX_IRQ_ENABLE = 6'd30;
	localparam logic [5:0] IDX_SPECIAL = 6'd31;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int REG_W = 16;

	// ----------------------------------------------------------------
	// Interrupt bit positions (flags and enable share one layout)
	// ----------------------------------------------------------------
	localparam int BIT_PAGE_RX = 1;
	localparam int BIT_PAR_FAULT = 2;
	localparam int BIT_LP_ACK = 3;
	localparam int BIT_LINK_DOWN = 4;
	localparam int BIT_REMOTE_FAULT = 5;
	localparam int BIT_ANEG_DONE = 6;
	localparam int BIT_ENERGY = 7;
	localparam int BIT_LINK_UP = 9;
	// Writable bits of the enable register; all others read as zero
	localparam logic [15:0] ENABLE_WMASK = 16'h02FE;
	localparam logic [15:0] ENABLE_RESET = 16'h0000;
	localparam logic [15:0] FLAGS_RESET = 16'h0000;

	// ----------------------------------------------------------------
	// Special control/status register fields
	// ----------------------------------------------------------------
	localparam int SPC_AUTODONE = 12;
	localparam int SPC_RESV_LO = 5;
	localparam int SPC_RESV_W = 7;
	localparam int SPC_SPEED_LO = 2;
	localparam logic [6:0] SPC_RESV_RESET = 7'b0000010;
	localparam logic [2:0] SPD_10_HALF = 3'b001;
	localparam logic [2:0] SPD_100_HALF = 3'b010;
	localparam logic [2:0] SPD_10_FULL = 3'b101;
	localparam logic [2:0] SPD_100_FULL = 3'b110;

	// ----------------------------------------------------------------
	// Carrier for the physical layer status pins
	// ----------------------------------------------------------------
	typedef struct packed {
		logic linkStatus;
		logic energyDetected;
		logic anegComplete;
		logic remoteFault;
		logic lpAck;
		logic parDetectFault;
		logic pageRx;
		logic [2:0] speedDuplex;
	} pis_phy_ev_s;

	// Whole state of the block
	typedef struct packed {
		pis_phy_ev_s sync1;
		pis_phy_ev_s sync2;
		pis_phy_ev_s prev;
		logic [15:0] enableReg;
		logic [15:0] flagsReg;
		logic [6:0] resvReg;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
	} pis_state_s;

endpackage

`default_nettype wire

// File: pis_irq_ctrl_tb.sv
// Self-checking bench for the PHY interrupt enable and special status block
`timescale 1ns/1ps
`default_nettype none

module pis_irq_ctrl_tb;
	// --------------------------------------------------------
	// Signals and tables
	// --------------------------------------------------------
	logic sys_clk, srst, psel, penable, pwrite, pready, pslverr, phyIrq, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	pis_pkg::pis_phy_ev_s ev;
	int failures, totalChecks, cycles;
	// Enable bit of each source and the pin position that raises it
	int srcBit[8] = '{1, 2, 3, 5, 6, 7, 9, 4};
	int pinPos[8] = '{3, 4, 5, 6, 7, 8, 9, 9};
	logic [2:0] codes[4] = '{pis_pkg::SPD_10_HALF, pis_pkg::SPD_100_HALF, pis_pkg::SPD_10_FULL, pis_pkg::SPD_100_FULL};
	localparam logic [7:0] A_FLAGS = {pis_pkg::IDX_IRQ_FLAGS, 2'b00};
	localparam logic [7:0] A_EN = {pis_pkg::IDX_IRQ_ENABLE, 2'b00};
	localparam logic [7:0] A_SPC = {pis_pkg::IDX_SPECIAL, 2'b00};

	pis_irq_ctrl uut (.sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .phyEvents(ev), .phyIrq(phyIrq));

	// Free-running 10 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	// --------------------------------------------------------
	// Shared tasks
	// --------------------------------------------------------
	task automatic close_out;
		$display("checks %0d failures %0d", totalChecks, failures);
		if (failures == 0 && totalChecks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		totalChecks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer; request held until pready is seen high at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge sys_clk);
			n++;
		end
		if (n == 20) failures++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	task automatic pin(input int p, input logic v);
		@(posedge sys_clk);
		ev[p] <= v;
		idle(4); // Sync plus latch latency is three edges
	endtask

	// --------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------
	task automatic t_reset_values;
		apb(1'b0, A_FLAGS, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		apb(1'b0, A_EN, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		apb(1'b0, A_SPC, 32'h0000_0000);
		chk(rd, 32'h0000_0040);
		chk({31'h0, phyIrq}, 32'h0000_0000);
	endtask

	task automatic t_enable_access;
		apb(1'b1, A_EN, 32'h0000_FFFF);
		apb(1'b0, A_EN, 32'h0000_0000);
		chk(rd, 32'h0000_02FE);
		apb(1'b1, A_EN, 32'h0000_0000);
		apb(1'b0, A_EN, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
	endtask

	// Each source alone enabled; last entry is the falling link edge
	task automatic t_sources;
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, A_EN, 32'h0000_0001 << srcBit[i]);
			pin(pinPos[i], i < 7);
			chk({31'h0, phyIrq}, 32'h0000_0001);
			apb(1'b0, A_FLAGS, 32'h0000_0000);
			chk(rd, 32'h0000_0001 << srcBit[i]);
			apb(1'b0, A_FLAGS, 32'h0000_0000);
			chk(rd, 32'h0000_0000);
			chk({31'h0, phyIrq}, 32'h0000_0000);
		end
		// Masked source must not latch
		apb(1'b1, A_EN, 32'h0000_0000);
		pin(3, 1'b0);
		pin(3, 1'b1);
		apb(1'b0, A_FLAGS, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
	endtask

	// Masking hides a latched flag; write-one clears it
	task automatic t_mask_clear;
		apb(1'b1, A_EN, 32'h0000_0002);
		pin(3, 1'b0);
		pin(3, 1'b1);
		chk({31'h0, phyIrq}, 32'h0000_0001);
		apb(1'b1, A_EN, 32'h0000_0000);
		idle(2);
		chk({31'h0, phyIrq}, 32'h0000_0000);
		apb(1'b1, A_EN, 32'h0000_0002);
		idle(2);
		chk({31'h0, phyIrq}, 32'h0000_0001);
		apb(1'b1, A_FLAGS, 32'h0000_0002);
		idle(2);
		chk({31'h0, phyIrq}, 32'h0000_0000);
	endtask

	task automatic t_special;
		apb(1'b1, A_SPC, 32'h0000_0040);
		for (int k = 0; k < 4; k++) begin
			@(posedge sys_clk);
			ev.speedDuplex <= codes[k];
			ev.anegComplete <= k[0];
			idle(4);
			apb(1'b0, A_SPC, 32'h0000_0000);
			chk(rd, (32'(k[0]) << 12) | 32'h0000_0040 | (32'(codes[k]) << 2));
		end
	endtask

	task automatic t_unmapped;
		apb(1'b0, 8'h00, 32'h0000_0000);
		chk({rd[31:1], err}, 32'h0000_0001);
		apb(1'b1, 8'h00, 32'h0000_FFFF);
		chk({31'h0, err}, 32'h0000_0001);
	endtask

	// --------------------------------------------------------
	// Main sequence and hang guard
	// --------------------------------------------------------
	initial begin
		srst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		pstrb = 4'hF;
		ev = '0;
		repeat (5) @(posedge sys_clk);
		srst <= 1'b0;
		t_reset_values();
		t_enable_access();
		t_sources();
		t_mask_clear();
		t_special();
		t_unmapped();
		close_out();
	end

	// Whole run needs well under a thousand cycles
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			close_out();
		end
	end
endmodule

`default_nettype wire
